/* sysmgmt_event_consts.vh */
// constants for the power-management event logic: port addresses, indexes, bit positions
// assumes inclusion from sysmgmt_event_logic.v only
`ifndef SYSMGMT_EVENT_CONSTS_VH
`define SYSMGMT_EVENT_CONSTS_VH
`define IO_ADDR_W            16
`define INDEX_PORT_ADDR      16'h0CD6
`define DATA_PORT_ADDR       16'h0CD7
`define GAME_PORT_ADDR       16'h0201
`define IDX_CONTROL          8'h00
`define IDX_SUMMARY          8'h01
`define IDX_IRQ_HIGH_EN      8'h02
`define IDX_IRQ_LOW_EN       8'h03
`define IDX_PERIPH_EN        8'h04
`define IDX_IRQ_HIGH_ST      8'h05
`define IDX_IRQ_LOW_ST       8'h06
`define IDX_PERIPH_ST        8'h07
`define IDX_RELOAD_EN_FIRST  8'h08
`define IDX_RELOAD_EN_LAST   8'h0A
`define IDX_RANGE_EN         8'h1C
`define IDX_RANGE_ST         8'h1D
`define IDX_HIGH_RANGE_EN    8'hA8
`define IDX_HIGH_RANGE_ST    8'hA9
`define BIT_EVENT            0
`define BIT_TIMER1           1
`define BIT_TIMER2           2
`define BIT_SWREQ            4
`define BIT_CLEAR_ALL        7
`define BIT_GAME             2
`define CONTROL_MASK         8'h16
`define SUMMARY_MASK         8'h17
`define BYTE_ZERO            8'h00
`endif

/* sysmgmt_event_logic.v */
// power-management event logic with index/data port access and interrupt generation
// assumes an 8-bit io cycle strobe on sys_clk_i; timer expiries and activity come from pins
//
// Notes on behaviour
// [RL1] index port write picks the register; data port reaches the picked register
// [RL2] data read returns picked register; data write updates that register, and also summary bit 4 (RL6) or the RL8 status clears
// [RL3] control bit 1 and timer 1 expiry set summary bit 1 and raise interrupt
// [RL4] control bit 1 clear disables all timer 1 reload enables at 08h-0Ah
// [RL5] timer 2 expiry sets summary bit 2; interrupt only with control bit 2
// [RL6] software request bit 4 sets summary bit 4 and raises interrupt
// [RL7] summary bit 0 set when enabled 02h/03h/04h/1Ch/A8h event raises interrupt
// [RL8] writing one to summary bit 7 clears 05h, 06h, 07h, 1Dh, A9h at once
// [RL9] first enable register gates irq 15..8 activity; resets to zero
// [RL10] second enable maps irq 7..3, nmi, irq 1..0 from bit 7 down
// [RL11] third enable bits: ext0, ext1, game, floppy, ide, serial, parallel, sleep
// [RL12] game port activity is an io access to 201h
// [RL13] first status bit set when matching irq 15..8 caused the interrupt
// [RL14] second status bit set when matching irq 7..0 caused the interrupt
// [RL15] third status records peripheral cause in enable bit order; write one clears
// [RL16] status and interrupt only for enabled sources, except summary bit 2 records timer 2 regardless; output ORs pending causes
// [RL17] all bits reset to zero; unimplemented indexes read zero, ignore writes
`include "sysmgmt_event_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module sysmgmt_event_logic (
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        rstn_i,
  // io cycle from the host bridge
  input  wire        io_strobe_i,
  input  wire        io_write_i,
  input  wire [15:0] io_addr_i,
  input  wire [7:0]  io_wdata_i,
  output wire [7:0]  io_rdata_o,
  // asynchronous event pins
  input  wire [7:0]  irq_high_activity_i,
  input  wire [7:0]  irq_low_nmi_activity_i,
  input  wire [7:0]  peripheral_activity_i,
  input  wire        inactivity_timer_one_expired_i,
  input  wire        inactivity_timer_two_expired_i,
  // range monitor status and reload enables from other logic, same clock
  input  wire [7:0]  range_monitor_event_i,
  input  wire [7:0]  high_range_monitor_event_i,
  input  wire [7:0]  reload_enable_08_i,
  input  wire [7:0]  reload_enable_09_i,
  input  wire [7:0]  reload_enable_0a_i,
  // outputs
  output wire [23:0] reload_enable_gated_o,
  output wire [7:0]  range_status_o,
  output wire [7:0]  high_range_status_o,
  output wire        system_management_interrupt_o
);

  // ************************************************************
  // synchronisers
  // ************************************************************
  // a change counts once the second and third stage agree
  localparam SYNC_W = 26;
  wire [SYNC_W-1:0] pins_raw;
  reg  [SYNC_W-1:0] sync1_reg;
  reg  [SYNC_W-1:0] sync2_reg;
  reg  [SYNC_W-1:0] sync3_reg;
  reg  [SYNC_W-1:0] stable_reg;
  reg  [SYNC_W-1:0] stable_prev_reg;
  assign pins_raw = {inactivity_timer_two_expired_i, inactivity_timer_one_expired_i,
                     peripheral_activity_i, irq_low_nmi_activity_i, irq_high_activity_i};

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g = g + 1) begin : g_sync
      always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sync1_reg[g]       <= 1'b0;
          sync2_reg[g]       <= 1'b0;
          sync3_reg[g]       <= 1'b0;
          stable_reg[g]      <= 1'b0;
          stable_prev_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g]       <= pins_raw[g];
          sync2_reg[g]       <= sync1_reg[g];
          sync3_reg[g]       <= sync2_reg[g];
          if (sync2_reg[g] == sync3_reg[g]) begin
            stable_reg[g] <= sync3_reg[g];
          end
          stable_prev_reg[g] <= stable_reg[g];
        end
      end
    end
  endgenerate

  // rising edges mark activity and expiry events
  wire [SYNC_W-1:0] rise = stable_reg & ~stable_prev_reg;
  wire [7:0] irq_high_act  = rise[7:0];
  wire [7:0] irq_low_act   = rise[15:8];
  wire [7:0] periph_pin    = rise[23:16];
  wire       timer1_exp    = rise[24];
  wire       timer2_exp    = rise[25];

  // ************************************************************
  // io decode
  // ************************************************************
  function is_port;
    input [15:0] addr;
    input [15:0] port;
    begin
      is_port = (addr == port);
    end
  endfunction

  reg  [7:0] index_reg;
  reg  [7:0] control_reg;
  reg  [7:0] summary_reg;
  reg  [7:0] irq_high_en_reg;
  reg  [7:0] irq_low_en_reg;
  reg  [7:0] periph_en_reg;
  reg  [7:0] irq_high_st_reg;
  reg  [7:0] irq_low_st_reg;
  reg  [7:0] periph_st_reg;
  reg  [7:0] range_st_reg;
  reg  [7:0] high_range_st_reg;
  reg  [7:0] rdata_reg;
  reg        smi_reg;
  reg  [23:0] reload_gated_reg;

  wire data_wr = io_strobe_i & io_write_i & is_port(io_addr_i, `DATA_PORT_ADDR); // RL1
  wire data_rd = io_strobe_i & ~io_write_i & is_port(io_addr_i, `DATA_PORT_ADDR);
  wire game_access = io_strobe_i & is_port(io_addr_i, `GAME_PORT_ADDR); // RL12

  function wr_to;
    input       wr;
    input [7:0] idx;
    input [7:0] target;
    begin
      wr_to = wr & (idx == target);
    end
  endfunction

  wire wr_ctrl   = wr_to(data_wr, index_reg, `IDX_CONTROL); // RL2
  wire wr_sum    = wr_to(data_wr, index_reg, `IDX_SUMMARY);
  wire wr_hen    = wr_to(data_wr, index_reg, `IDX_IRQ_HIGH_EN);
  wire wr_len    = wr_to(data_wr, index_reg, `IDX_IRQ_LOW_EN);
  wire wr_pen    = wr_to(data_wr, index_reg, `IDX_PERIPH_EN);
  wire wr_hst    = wr_to(data_wr, index_reg, `IDX_IRQ_HIGH_ST);
  wire wr_lst    = wr_to(data_wr, index_reg, `IDX_IRQ_LOW_ST);
  wire wr_pst    = wr_to(data_wr, index_reg, `IDX_PERIPH_ST);
  wire clear_all = wr_sum & io_wdata_i[`BIT_CLEAR_ALL]; // RL8

  // ************************************************************
  // event qualification
  // ************************************************************
  // peripheral sources named in enable bit order
  wire external_event_zero_act = periph_pin[0];
  wire external_event_one_act  = periph_pin[1];
  wire game_port_act           = periph_pin[`BIT_GAME] | game_access; // RL12
  wire floppy_act              = periph_pin[3];
  wire disk_act                = periph_pin[4];
  wire serial_port_act         = periph_pin[5];
  wire parallel_port_act       = periph_pin[6];
  wire sleep_command_act       = periph_pin[7];
  wire [7:0] periph_act = {sleep_command_act, parallel_port_act, serial_port_act, disk_act,
                           floppy_act, game_port_act, external_event_one_act,
                           external_event_zero_act}; // RL11
  wire [7:0] high_hit  = irq_high_act & irq_high_en_reg; // RL9 RL16
  wire [7:0] low_hit   = irq_low_act & irq_low_en_reg; // RL10 RL16
  wire [7:0] per_hit   = periph_act & periph_en_reg; // RL16
  wire       event_hit = (|high_hit) | (|low_hit) | (|per_hit) |
                         (|range_monitor_event_i) | (|high_range_monitor_event_i); // RL7
  wire       swreq_set = wr_ctrl & io_wdata_i[`BIT_SWREQ]; // RL6

  // ************************************************************
  // registers
  // ************************************************************
  // write one clears; a hardware set wins over a clear in the same cycle
  function [7:0] w1c_next;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    begin
      w1c_next = set | (cur & ~clr);
    end
  endfunction

  wire       index_wr = io_strobe_i & io_write_i & is_port(io_addr_i, `INDEX_PORT_ADDR); // RL1
  wire [7:0] all_clr  = {8{clear_all}}; // RL8
  wire [7:0] sum_clr  = {8{wr_sum}} & io_wdata_i;
  wire [7:0] sum_set  = {3'h0, swreq_set, 1'h0, timer2_exp,
                         timer1_exp & control_reg[`BIT_TIMER1], event_hit}; // RL3 RL5 RL6
  wire [7:0] hst_clr  = all_clr | ({8{wr_hst}} & io_wdata_i);
  wire [7:0] lst_clr  = all_clr | ({8{wr_lst}} & io_wdata_i);
  wire [7:0] pst_clr  = all_clr | ({8{wr_pst}} & io_wdata_i); // RL15

  reg  [7:0] index_next;
  reg  [7:0] control_next;
  reg  [7:0] summary_next;
  reg  [7:0] irq_high_en_next;
  reg  [7:0] irq_low_en_next;
  reg  [7:0] periph_en_next;
  reg  [7:0] irq_high_st_next;
  reg  [7:0] irq_low_st_next;
  reg  [7:0] periph_st_next;
  reg  [7:0] range_st_next;
  reg  [7:0] high_range_st_next;

  // ************************************************************
  // next-state logic
  // ************************************************************
  always @* begin
    // plain read/write registers
    index_next       = index_reg;
    control_next     = control_reg;
    irq_high_en_next = irq_high_en_reg;
    irq_low_en_next  = irq_low_en_reg;
    periph_en_next   = periph_en_reg;

    if (index_wr) begin
      index_next = io_wdata_i; // RL1
    end
    if (wr_ctrl) begin
      control_next = io_wdata_i & `CONTROL_MASK;
    end

    if (wr_hen) begin
      irq_high_en_next = io_wdata_i; // RL9
    end
    if (wr_len) begin
      irq_low_en_next = io_wdata_i; // RL10
    end
    if (wr_pen) begin
      periph_en_next = io_wdata_i; // RL11
    end

    // reserved summary bits and the write-only clear bit read back as zero
    summary_next       = w1c_next(summary_reg, sum_set, sum_clr) & `SUMMARY_MASK; // RL7

    // write-one-to-clear status
    irq_high_st_next   = w1c_next(irq_high_st_reg, high_hit, hst_clr); // RL13
    irq_low_st_next    = w1c_next(irq_low_st_reg, low_hit, lst_clr); // RL14
    periph_st_next     = w1c_next(periph_st_reg, per_hit, pst_clr); // RL15

    // monitor status only clears through the clear-all bit
    range_st_next      = w1c_next(range_st_reg, range_monitor_event_i, all_clr); // RL8
    high_range_st_next = w1c_next(high_range_st_reg, high_range_monitor_event_i, all_clr); // RL8
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin // RL17
      index_reg         <= `BYTE_ZERO;
      control_reg       <= `BYTE_ZERO;
      summary_reg       <= `BYTE_ZERO;
      irq_high_en_reg   <= `BYTE_ZERO;
      irq_low_en_reg    <= `BYTE_ZERO;
      periph_en_reg     <= `BYTE_ZERO;
      irq_high_st_reg   <= `BYTE_ZERO;
      irq_low_st_reg    <= `BYTE_ZERO;
      periph_st_reg     <= `BYTE_ZERO;
      range_st_reg      <= `BYTE_ZERO;
      high_range_st_reg <= `BYTE_ZERO;
    end else begin
      // enables and control
      index_reg         <= index_next;
      control_reg       <= control_next;
      irq_high_en_reg   <= irq_high_en_next;
      irq_low_en_reg    <= irq_low_en_next;
      periph_en_reg     <= periph_en_next;
      // status
      summary_reg       <= summary_next;
      irq_high_st_reg   <= irq_high_st_next;
      irq_low_st_reg    <= irq_low_st_next;
      periph_st_reg     <= periph_st_next;
      range_st_reg      <= range_st_next;
      high_range_st_reg <= high_range_st_next;
    end
  end

  // ************************************************************
  // read mux, interrupt and outputs
  // ************************************************************
  reg [7:0] rdata_next;
  always @* begin
    case (index_reg) // RL2
      `IDX_CONTROL:       rdata_next = control_reg;
      `IDX_SUMMARY:       rdata_next = summary_reg;
      `IDX_IRQ_HIGH_EN:   rdata_next = irq_high_en_reg;
      `IDX_IRQ_LOW_EN:    rdata_next = irq_low_en_reg;
      `IDX_PERIPH_EN:     rdata_next = periph_en_reg;
      `IDX_IRQ_HIGH_ST:   rdata_next = irq_high_st_reg;
      `IDX_IRQ_LOW_ST:    rdata_next = irq_low_st_reg;
      `IDX_PERIPH_ST:     rdata_next = periph_st_reg;
      `IDX_RANGE_ST:      rdata_next = range_st_reg;
      `IDX_HIGH_RANGE_ST: rdata_next = high_range_st_reg;
      default:            rdata_next = `BYTE_ZERO; // RL17
    endcase
  end

  // level interrupt: held while any enabled cause is still pending
  wire smi_next = (|irq_high_st_reg) | (|irq_low_st_reg) | (|periph_st_reg) |
                  (|range_st_reg) | (|high_range_st_reg) |
                  (summary_reg[`BIT_TIMER1] & control_reg[`BIT_TIMER1]) |
                  (summary_reg[`BIT_TIMER2] & control_reg[`BIT_TIMER2]) |
                  summary_reg[`BIT_SWREQ]; // RL16 RL3 RL5 RL6

  // read data holds between data-port reads so a slow host can still pick it up
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_reg <= `BYTE_ZERO;
    end else if (data_rd) begin
      rdata_reg <= rdata_next; // RL2
    end
  end

  // registered so the pin never glitches while status bits settle
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      smi_reg <= 1'b0;
    end else begin
      smi_reg <= smi_next; // RL16
    end
  end

  // the gate costs one cycle of latency on the reload enables
  wire [23:0] reload_raw = {reload_enable_0a_i, reload_enable_09_i, reload_enable_08_i};

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reload_gated_reg <= 24'h000000;
    end else begin
      reload_gated_reg <= reload_raw & {24{control_reg[`BIT_TIMER1]}}; // RL4
    end
  end

  assign io_rdata_o                    = rdata_reg;
  assign system_management_interrupt_o = smi_reg;
  assign reload_enable_gated_o         = reload_gated_reg;
  assign range_status_o                = range_st_reg;
  assign high_range_status_o           = high_range_st_reg;

endmodule // sysmgmt_event_logic

`default_nettype wire

/* sysmgmt_event_properties.sv */
// checker for the power-management event logic, watching the top ports only
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module sysmgmt_event_properties (
  // clock, reset and io cycle
  input wire logic        sys_clk_i, rstn_i, io_strobe_i, io_write_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [7:0]  io_wdata_i, io_rdata_o,
  // event inputs
  input wire logic [7:0]  irq_high_activity_i, irq_low_nmi_activity_i, peripheral_activity_i,
  input wire logic        inactivity_timer_one_expired_i, inactivity_timer_two_expired_i,
  input wire logic [7:0]  range_monitor_event_i, high_range_monitor_event_i,
  input wire logic [7:0]  reload_enable_08_i, reload_enable_09_i, reload_enable_0a_i,
  // outputs
  input wire logic [23:0] reload_enable_gated_o,
  input wire logic [7:0]  range_status_o, high_range_status_o,
  input wire logic        system_management_interrupt_o
);
  logic [7:0] idx_reg;
  logic [7:0] shadow_reg [0:4];
  wire        dwr = io_strobe_i && io_write_i && io_addr_i == 16'h0CD7;
  wire        drd = io_strobe_i && !io_write_i && io_addr_i == 16'h0CD7;
  wire [23:0] rel_in = {reload_enable_0a_i, reload_enable_09_i, reload_enable_08_i};
  wire        clr_all = dwr && idx_reg == 8'h01 && io_wdata_i[7];
  wire        unmapped = idx_reg > 8'h07 && idx_reg != 8'h1D && idx_reg != 8'hA9;
  wire [7:0]  shadow_sel = shadow_reg[idx_reg[2:0]];
  wire        t1_en = shadow_reg[0][1];
  // shadow of the plain read/write registers; index 1 is stored but never compared
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idx_reg <= 8'h00;
      for (int i = 0; i < 5; i++)
        shadow_reg[i] <= 8'h00;
    end else begin
      if (io_strobe_i && io_write_i && io_addr_i == 16'h0CD6)
        idx_reg <= io_wdata_i;
      if (dwr && idx_reg < 8'h05)
        shadow_reg[idx_reg[2:0]] <= io_wdata_i & (idx_reg == 8'h00 ? 8'h16 : 8'hFF);
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  reset_quiet_a: assert property ($past(!rstn_i) |-> !system_management_interrupt_o)
    else $error("interrupt high right after reset");
  rdata_hold_a: assert property (!drd |=> $stable(io_rdata_o))
    else $error("read data changed without a data read");
  unmapped_read_a: assert property (drd && unmapped |=> io_rdata_o == 8'h00)
    else $error("unimplemented index read not zero");
  shadow_read_a: assert property (drd && idx_reg < 8'h05 && idx_reg != 8'h01
    |=> io_rdata_o == $past(shadow_sel))
    else $error("register read differs from last write");
  swreq_raise_a: assert property (dwr && idx_reg == 8'h00 && io_wdata_i[4]
    |-> ##[1:2] system_management_interrupt_o)
    else $error("software request raised no interrupt");
  gate_off_a: assert property (!t1_en && $past(!t1_en) |-> reload_enable_gated_o == 24'h000000)
    else $error("reload enables pass while gate closed");
  gate_on_a: assert property (t1_en && $past(t1_en) && $stable(rel_in)
    |-> reload_enable_gated_o == rel_in)
    else $error("reload enables blocked while gate open");
  range_set_a: assert property (!clr_all && range_monitor_event_i != 8'h00
    |=> (range_status_o & $past(range_monitor_event_i)) == $past(range_monitor_event_i))
    else $error("range status not recorded");
  clear_all_a: assert property (clr_all && range_monitor_event_i == 8'h00
    && high_range_monitor_event_i == 8'h00
    |=> range_status_o == 8'h00 && high_range_status_o == 8'h00)
    else $error("clear all left range status set");
  swreq_c: cover property (dwr && idx_reg == 8'h00 && io_wdata_i[4]);
  clear_all_c: cover property (clr_all);
  unmapped_c: cover property (drd && unmapped);
endmodule // sysmgmt_event_properties
bind sysmgmt_event_logic sysmgmt_event_properties sysmgmt_event_properties_i (.*);
`default_nettype wire

/* sysmgmt_event_logic_tb.sv */
// self-checking bench for the power-management event logic
// assumes a 100 MHz clock; the bench drives every port through io cycles and pins
`timescale 1ns/1ps
`default_nettype none
module sysmgmt_event_logic_tb;
  logic        sys_clk_i = 1'b0, rstn_i = 1'b0, io_strobe_i = 1'b0, io_write_i = 1'b0;
  logic [15:0] io_addr_i = 16'h0000;
  logic [7:0]  io_wdata_i = 8'h00, irq_high_activity_i = 8'h00, irq_low_nmi_activity_i = 8'h00;
  logic [7:0]  peripheral_activity_i = 8'h00, range_monitor_event_i = 8'h00;
  logic [7:0]  high_range_monitor_event_i = 8'h00, reload_enable_08_i = 8'h00;
  logic [7:0]  reload_enable_09_i = 8'h00, reload_enable_0a_i = 8'h00;
  logic        inactivity_timer_one_expired_i = 1'b0, inactivity_timer_two_expired_i = 1'b0;
  wire [7:0]   io_rdata_o, range_status_o, high_range_status_o;
  wire [23:0]  reload_enable_gated_o;
  wire         system_management_interrupt_o;
  int          n_fail = 0;
  int          checks_done = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  sysmgmt_event_logic sysmgmt_event_logic_i (.*);
  task automatic finish_test;
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one idle edge between cycles so the strobe is never assigned twice in a step
  task automatic io_cyc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    io_strobe_i <= 1'b1;
    io_write_i <= wr;
    io_addr_i <= a;
    io_wdata_i <= d;
    @(posedge sys_clk_i);
    io_strobe_i <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pm_wr(input logic [7:0] i, input logic [7:0] d);
    io_cyc(1'b1, 16'h0CD6, i);
    io_cyc(1'b1, 16'h0CD7, d);
  endtask
  task automatic pm_chk(input logic [7:0] i, input logic [7:0] exp);
    io_cyc(1'b1, 16'h0CD6, i);
    io_cyc(1'b0, 16'h0CD7, 8'h00);
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(io_rdata_o, exp);
  endtask
  task automatic wait_smi(input logic exp);
    int k;
    for (k = 0; k < 12 && system_management_interrupt_o !== exp; k++)
      @(negedge sys_clk_i);
    chk({7'h00, system_management_interrupt_o}, {7'h00, exp});
    if (k == 12)
      finish_test();
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 8; i++)
      pm_chk(i[7:0], 8'h00);
    pm_wr(8'h02, 8'h08);
    pm_wr(8'h03, 8'h04);
    pm_wr(8'h04, 8'h04);
    pm_wr(8'h40, 8'hFF);
    pm_chk(8'h40, 8'h00);
    pm_chk(8'h02, 8'h08);
    pm_chk(8'h03, 8'h04);
    pm_chk(8'h04, 8'h04);
    // enabled and disabled sources rise together; only enabled ones may record
    @(posedge sys_clk_i);
    irq_high_activity_i <= 8'h0C;
    irq_low_nmi_activity_i <= 8'h05;
    peripheral_activity_i <= 8'h08;
    wait_smi(1'b1);
    io_cyc(1'b0, 16'h0201, 8'h00);
    pm_chk(8'h05, 8'h08);
    pm_chk(8'h06, 8'h04);
    pm_chk(8'h07, 8'h04);
    pm_chk(8'h01, 8'h01);
    pm_wr(8'h01, 8'h80);
    pm_chk(8'h05, 8'h00);
    pm_chk(8'h06, 8'h00);
    pm_chk(8'h07, 8'h00);
    pm_wr(8'h01, 8'h01);
    wait_smi(1'b0);
    pm_wr(8'h00, 8'h10);
    wait_smi(1'b1);
    pm_chk(8'h01, 8'h10);
    pm_wr(8'h00, 8'h00);
    pm_wr(8'h01, 8'h10);
    wait_smi(1'b0);
    // timer 2 always records, interrupts only when enabled
    @(posedge sys_clk_i);
    inactivity_timer_two_expired_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    pm_chk(8'h01, 8'h04);
    chk({7'h00, system_management_interrupt_o}, 8'h00);
    @(posedge sys_clk_i);
    inactivity_timer_two_expired_i <= 1'b0;
    pm_wr(8'h01, 8'h04);
    pm_wr(8'h00, 8'h04);
    inactivity_timer_two_expired_i <= 1'b1;
    wait_smi(1'b1);
    pm_wr(8'h00, 8'h00);
    pm_wr(8'h01, 8'h04);
    wait_smi(1'b0);
    @(posedge sys_clk_i);
    reload_enable_08_i <= 8'hA5;
    reload_enable_09_i <= 8'h3C;
    reload_enable_0a_i <= 8'h7E;
    pm_chk(8'h00, 8'h00);
    chk(reload_enable_gated_o[7:0], 8'h00);
    chk(reload_enable_gated_o[15:8], 8'h00);
    pm_wr(8'h00, 8'h02);
    inactivity_timer_one_expired_i <= 1'b1;
    wait_smi(1'b1);
    chk(reload_enable_gated_o[23:16], 8'h7E);
    chk(reload_enable_gated_o[15:8], 8'h3C);
    chk(reload_enable_gated_o[7:0], 8'hA5);
    pm_chk(8'h01, 8'h02);
    @(posedge sys_clk_i);
    range_monitor_event_i <= 8'h21;
    high_range_monitor_event_i <= 8'h81;
    @(posedge sys_clk_i);
    range_monitor_event_i <= 8'h00;
    high_range_monitor_event_i <= 8'h00;
    pm_chk(8'h1D, 8'h21);
    chk(high_range_status_o, 8'h81);
    pm_wr(8'h01, 8'h80);
    @(negedge sys_clk_i);
    chk(range_status_o | high_range_status_o, 8'h00);
    finish_test();
  end
endmodule // sysmgmt_event_logic_tb
`default_nettype wire
